// ==== qflash_read_ctrl.sv ====
`timescale 1ns/100ps
// Contract
// [RULE1] Always the controller: drives serial clock and chip select itself
// [RULE2] Reads on one, two or four data lines
// [RULE3] Mapped read request becomes a serial read without software steps
// [RULE4] Word length programmable from 1 to 128 bits
// [RULE5] Words per frame programmable from 1 to 4096
// [RULE6] Three, four or six pin link; wider ones add data lines
// [RULE7] Optional event per word or per whole frame
// [RULE8] Zero to three serial clocks between select and first data
// [RULE9] Clock mode 0 only: clock idles low, phase zero
// [RULE10] Read data captured on falling clock; peer launches on falling
// [RULE11] Select released about two clock periods after last falling edge
// [RULE12] Serial clock from divider, held low while select inactive
// [RULE13] Select held for whole frame, dropped after last bit captured
module qflash_read_ctrl (
    input  wire logic                           ref_clk_i,
    input  wire logic                           reset_n_i,
    input  wire logic                           link_clk_i,
    input  wire logic [1:0]                     read_mode_i,
    input  wire logic [1:0]                     pin_mode_i,
    input  wire logic [qflash_pkg::LEN_W-1:0]   word_len_i,
    input  wire logic [qflash_pkg::CNT_W-1:0]   word_cnt_i,
    input  wire logic [1:0]                     cs_delay_i,
    input  wire logic [qflash_pkg::DIV_W-1:0]   clk_div_i,
    input  wire logic                           evt_word_i,
    input  wire logic                           evt_frame_i,
    input  wire logic                           mm_req_i,
    input  wire logic [qflash_pkg::ADDR_W-1:0]  mm_addr_i,
    input  wire logic                           sw_req_i,
    input  wire logic [qflash_pkg::CMD_W-1:0]   sw_cmd_i,
    input  wire logic [qflash_pkg::ADDR_W-1:0]  sw_addr_i,
    output logic                                busy_o,
    output logic [qflash_pkg::WORD_W-1:0]       rd_data_o,
    output logic                                rd_last_o,
    output logic                                rd_valid_o,
    input  wire logic                           rd_ready_i,
    output logic                                event_o,
    output logic                                sclk_o,
    output logic                                cs_n_o,
    output logic [3:0]                          sd_o,
    output logic [3:0]                          sd_oe_n_o,
    input  wire logic [3:0]                     sd_i
);
    import qflash_pkg::*;

    // Active lanes; dual or quad fall back when the pins are missing
    function automatic logic [2:0] lanes(input logic [1:0] rd,
                                         input logic [1:0] pins);
        if (rd == RD_QUAD && pins == PINS_6) begin
            lanes = 3'h4;
        end else if (rd != RD_SINGLE && pins != PINS_3) begin
            lanes = 3'h2;
        end else begin
            lanes = 3'h1;
        end
    endfunction : lanes

    // ****************************************************************
    // Reference domain: request capture and word intake
    // ****************************************************************
    logic [HDR_W-1:0]  h_hdr_q;
    logic [1:0]        h_rd_q;
    logic [1:0]        h_pins_q;
    logic [LEN_W-1:0]  h_len_q;
    logic [CNT_W-1:0]  h_cnt_q;
    logic [1:0]        h_dly_q;
    logic [DIV_W-1:0]  h_div_q;
    logic              busy_q;
    logic              rtgl_q;
    logic              wreq_s1;
    logic              wreq_s2;
    logic              wack_q;
    logic              evt_q;
    logic              pending;
    logic              buf_ready;
    logic              push;
    logic              accept;
    logic [7:0]        mm_cmd;
    // Link-side word registers, read here only behind the handshake
    logic              wreq_q;
    logic              wlast_q;
    logic [WORD_W-1:0] wdata_q;

    assign accept  = !busy_q && (mm_req_i || sw_req_i);
    assign pending = wreq_s2 != wack_q;
    assign push    = pending && buf_ready;
    assign busy_o  = busy_q;
    assign event_o = evt_q;

    // Mapped command follows the chosen read width
    always_comb begin
        unique case (read_mode_i)
            RD_DUAL: mm_cmd = CMD_DUAL;
            RD_QUAD: mm_cmd = CMD_QUAD;
            default: mm_cmd = CMD_SINGLE;
        endcase
    end

    // Frame setup; held stable for the link side until busy drops as the last word enters the buffer
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            h_hdr_q  <= '0;
            h_rd_q   <= RD_SINGLE;
            h_pins_q <= PINS_3;
            h_len_q  <= '0;
            h_cnt_q  <= '0;
            h_dly_q  <= 2'h0;
            h_div_q  <= '0;
            rtgl_q   <= 1'b0;
        end else if (accept) begin
            h_hdr_q  <= mm_req_i ? {mm_cmd, mm_addr_i}   // [RULE3]
                                 : {sw_cmd_i, sw_addr_i};
            h_rd_q   <= read_mode_i;
            h_pins_q <= pin_mode_i;
            h_len_q  <= word_len_i;
            h_cnt_q  <= word_cnt_i;
            h_dly_q  <= cs_delay_i;
            h_div_q  <= clk_div_i;
            rtgl_q   <= ~rtgl_q;
        end
    end

    // Busy from acceptance until the last word enters the buffer
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            busy_q <= 1'b0;
        end else if (accept) begin
            busy_q <= 1'b1;
        end else if (push && wlast_q) begin
            busy_q <= 1'b0;
        end
    end

    // Word handshake from the link side; ack only when buffer has room
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            wreq_s1 <= 1'b0;
            wreq_s2 <= 1'b0;
            wack_q  <= 1'b0;
        end else begin
            wreq_s1 <= wreq_q;
            wreq_s2 <= wreq_s1;
            if (push) begin
                wack_q <= wreq_s2;
            end
        end
    end

    // Completion event, one cycle per word or per frame
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            evt_q <= 1'b0;
        end else begin
            evt_q <= push                                   // [RULE7]
                     && (evt_word_i || (evt_frame_i && wlast_q));
        end
    end

    // Stall by the reader holds the ack, which stalls the serial clock
    word_buf2 #(
        .W (WORD_W + 1)
    ) word_buf2_i (
        .clk_i       (ref_clk_i),
        .rst_n_i     (reset_n_i),
        .in_data_i   ({wlast_q, wdata_q}),
        .in_valid_i  (pending),
        .in_ready_o  (buf_ready),
        .out_data_o  ({rd_last_o, rd_data_o}),
        .out_valid_o (rd_valid_o),
        .out_ready_i (rd_ready_i)
    );

    // ****************************************************************
    // Link domain: serial engine
    // ****************************************************************
    link_state_e       st_q;
    logic              lrst_s1;
    logic              lrst_n_q;
    logic              rtgl_s1;
    logic              rtgl_s2;
    logic              rseen_q;
    logic              wack_s1;
    logic              wack_s2;
    logic [3:0]        din_s1;
    logic [3:0]        din_s2;
    logic [DIV_W-1:0]  hcnt_q;
    logic              sclk_q;
    logic              cs_n_q;
    logic [3:0]        sd_o_q;
    logic [3:0]        sd_oe_n_q;
    logic [HDR_W-1:0]  hdr_q;
    logic [5:0]        hbits_q;
    logic [WORD_W-1:0] sh_q;
    logic [7:0]        acc_q;
    logic [CNT_W-1:0]  wcnt_q;
    logic [2:0]        lcnt_q;
    logic              tick;
    logic              lpend;
    logic [2:0]        w;
    logic [7:0]        acc_nx;
    logic [WORD_W-1:0] sh_nx;
    logic              din_bit;
    logic [WORD_W-1:0] len_mask;

    assign sclk_o    = sclk_q;
    assign cs_n_o    = cs_n_q;
    assign sd_o      = sd_o_q;
    assign sd_oe_n_o = sd_oe_n_q;
    assign tick      = hcnt_q == '0;
    assign lpend     = wreq_q != wack_s2;
    assign w         = lanes(h_rd_q, h_pins_q); // [RULE2]
    assign acc_nx    = 8'(acc_q + {5'h0, w});
    // Three-pin link reads back on the shared line
    assign din_bit   = (h_pins_q == PINS_3) ? din_s2[0] : din_s2[1];
    // Bits shifted past the word length are cleared, not handed over
    assign len_mask  = ~(({WORD_W{1'b1}} << h_len_q) << 1);

    // New bits shifted in on each capture
    always_comb begin
        unique case (w)
            3'h4:    sh_nx = {sh_q[WORD_W-5:0], din_s2};
            3'h2:    sh_nx = {sh_q[WORD_W-3:0], din_s2[1:0]};
            default: sh_nx = {sh_q[WORD_W-2:0], din_bit};
        endcase
    end

    // Reset into the link domain
    always_ff @(posedge link_clk_i) begin
        lrst_s1  <= reset_n_i;
        lrst_n_q <= lrst_s1;
    end

    // Synchronisers for request, ack and data pins
    always_ff @(posedge link_clk_i) begin
        if (!lrst_n_q) begin
            rtgl_s1 <= 1'b0;
            rtgl_s2 <= 1'b0;
            wack_s1 <= 1'b0;
            wack_s2 <= 1'b0;
            din_s1  <= 4'h0;
            din_s2  <= 4'h0;
        end else begin
            rtgl_s1 <= rtgl_q;
            rtgl_s2 <= rtgl_s1;
            wack_s1 <= wack_q;
            wack_s2 <= wack_s1;
            din_s1  <= sd_i;
            din_s2  <= din_s1;
        end
    end

    // Half-period divider; it stops while idle or stalled
    // A setting of zero is too fast for the two-stage pin synchroniser
    always_ff @(posedge link_clk_i) begin
        if (!lrst_n_q) begin
            hcnt_q <= '0;
        end else if (st_q == ST_IDLE || st_q == ST_STALL || tick) begin
            hcnt_q <= h_div_q; // [RULE12]
        end else begin
            hcnt_q <= hcnt_q - 8'h1;
        end
    end

    // Frame sequencer and pin drivers
    always_ff @(posedge link_clk_i) begin
        if (!lrst_n_q) begin
            st_q      <= ST_IDLE;
            rseen_q   <= 1'b0;
            sclk_q    <= 1'b0;
            cs_n_q    <= CS_IDLE;
            sd_o_q    <= SD_IDLE;
            sd_oe_n_q <= OE_OFF;
            hdr_q     <= '0;
            hbits_q   <= '0;
            sh_q      <= '0;
            acc_q     <= '0;
            wcnt_q    <= '0;
            lcnt_q    <= '0;
            wreq_q    <= 1'b0;
            wlast_q   <= 1'b0;
            wdata_q   <= '0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    sclk_q <= 1'b0; // [RULE9]
                    if (rtgl_s2 != rseen_q) begin
                        rseen_q      <= rtgl_s2;
                        cs_n_q       <= 1'b0; // [RULE1]
                        hdr_q        <= h_hdr_q;
                        hbits_q      <= HDR_BITS;
                        sd_o_q       <= {2'h3, 1'b0, h_hdr_q[HDR_W-1]};
                        // Six-pin single or dual keeps the spare lines high
                        sd_oe_n_q    <= (h_pins_q == PINS_6)  // [RULE6]
                                        ? 4'h2 : 4'he;
                        sh_q         <= '0;
                        acc_q        <= '0;
                        wcnt_q       <= '0;
                        lcnt_q       <= '0;
                        st_q         <= ST_LEAD;
                    end
                end
                ST_LEAD: begin
                    if (tick) begin
                        if (lcnt_q == {h_dly_q, 1'b0}) begin // [RULE8]
                            st_q <= ST_SHIFT;
                        end else begin
                            lcnt_q <= lcnt_q + 3'h1;
                        end
                    end
                end
                ST_SHIFT: begin
                    if (tick && !sclk_q) begin
                        sclk_q <= 1'b1;
                    end else if (tick) begin
                        sclk_q <= 1'b0;
                        if (hbits_q != '0) begin
                            hbits_q   <= hbits_q - 6'h1;
                            hdr_q     <= {hdr_q[HDR_W-2:0], 1'b0};
                            sd_o_q[0] <= hdr_q[HDR_W-2];
                            if (hbits_q == 6'h1) begin
                                // Peer takes the lines from here on
                                sd_oe_n_q[1:0] <= 2'h3;
                                if (w == 3'h4) begin
                                    sd_oe_n_q[3:2] <= 2'h3;
                                end
                            end
                        end else begin
                            sh_q <= sh_nx; // [RULE10]
                            if (acc_nx > {1'b0, h_len_q}) begin // [RULE4]
                                acc_q <= '0;
                                st_q  <= ST_STALL;
                            end else begin
                                acc_q <= acc_nx;
                            end
                        end
                    end
                end
                ST_STALL: begin
                    // Clock rests low until the previous word is taken
                    if (!lpend) begin
                        wdata_q <= sh_q & len_mask; // [RULE4]
                        wlast_q <= wcnt_q == h_cnt_q; // [RULE5]
                        wreq_q  <= ~wreq_q;
                        wcnt_q  <= wcnt_q + 12'h1;
                        sh_q    <= '0;
                        lcnt_q  <= '0;
                        st_q    <= (wcnt_q == h_cnt_q) ? ST_TAIL // [RULE13]
                                                       : ST_SHIFT;
                    end
                end
                ST_TAIL: begin
                    if (tick) begin
                        if (lcnt_q == TAIL_LAST) begin // [RULE11]
                            cs_n_q    <= CS_IDLE;
                            sd_o_q    <= SD_IDLE;
                            sd_oe_n_q <= OE_OFF;
                            st_q      <= ST_IDLE;
                        end else begin
                            lcnt_q <= lcnt_q + 3'h1;
                        end
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence cs_fall_s;
        $fell(cs_n_q);
    endsequence

    sequence sclk_fall_s;
        $fell(sclk_q);
    endsequence

    req_accept_a: assert property ( // [RULE3]
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (!busy_q && mm_req_i) |=> busy_q && h_hdr_q[23:0] == $past(mm_addr_i)
    ) else $error("mapped request not taken");

    word_event_a: assert property ( // [RULE7]
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (push && evt_word_i) |=> evt_q
    ) else $error("word event missing");

    event_cause_a: assert property ( // [RULE7]
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        evt_q |-> $past(push) && ($past(evt_word_i) || $past(wlast_q))
    ) else $error("event without cause");

    idle_clock_a: assert property ( // [RULE12]
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        cs_n_q |-> !sclk_q
    ) else $error("clock toggles while deselected");

    clock_mode_a: assert property ( // [RULE9]
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        cs_fall_s |-> !sclk_q [*2]
    ) else $error("clock not low at select");

    lead_delay_a: assert property ( // [RULE8]
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        cs_fall_s ##0 (h_dly_q == 2'h3) |-> !sclk_q [*7]
    ) else $error("select to data delay too short");

    rise_only_a: assert property ( // [RULE1]
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        $rose(sclk_q) |-> !cs_n_q && st_q == ST_SHIFT
    ) else $error("clock edge outside frame");

    word_len_a: assert property ( // [RULE4]
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        ($past(st_q) == ST_SHIFT && st_q == ST_STALL)
            |-> $past(acc_nx) > {1'b0, h_len_q}
    ) else $error("word ended early");

    word_cnt_a: assert property ( // [RULE5]
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        $changed(wreq_q) |-> $past(wcnt_q) <= h_cnt_q
    ) else $error("too many words in frame");

    capture_fall_a: assert property ( // [RULE10]
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        ($changed(acc_q) && st_q == ST_SHIFT) |-> sclk_fall_s
    ) else $error("capture off falling edge");

    cs_release_a: assert property ( // [RULE13]
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        $rose(cs_n_q) |-> $past(st_q) == ST_TAIL && wlast_q // [RULE11]
    ) else $error("select dropped mid frame");

    lane_oe_a: assert property ( // [RULE6]
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        (h_pins_q != PINS_6) |-> sd_oe_n_q[3:2] == 2'h3
    ) else $error("spare lines driven");

endmodule : qflash_read_ctrl

// ==== qflash_pkg.sv ====
package qflash_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int WORD_W = 128;
    localparam int LEN_W  = 7;
    localparam int CNT_W  = 12;
    localparam int DIV_W  = 8;
    localparam int ADDR_W = 24;
    localparam int CMD_W  = 8;
    localparam int HDR_W  = 32;

    // ****************************************************************
    // Read width and pin configuration codes
    // ****************************************************************
    localparam logic [1:0] RD_SINGLE = 2'h0;
    localparam logic [1:0] RD_DUAL   = 2'h1;
    localparam logic [1:0] RD_QUAD   = 2'h2;
    localparam logic [1:0] PINS_3    = 2'h0;
    localparam logic [1:0] PINS_4    = 2'h1;
    localparam logic [1:0] PINS_6    = 2'h2;

    // ****************************************************************
    // Mapped-read commands, counts and reset values
    // ****************************************************************
    localparam logic [7:0] CMD_SINGLE = 8'h03;
    localparam logic [7:0] CMD_DUAL   = 8'h3b;
    localparam logic [7:0] CMD_QUAD   = 8'h6b;
    localparam logic [5:0] HDR_BITS   = 6'h20;
    localparam logic [2:0] TAIL_LAST  = 3'h3;
    localparam logic       CS_IDLE    = 1'b1;
    localparam logic [3:0] OE_OFF     = 4'hf;
    localparam logic [3:0] SD_IDLE    = 4'h0;

    // Serial engine states, Gray along idle-lead-shift-stall-tail
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LEAD  = 3'b001,
        ST_SHIFT = 3'b011,
        ST_STALL = 3'b010,
        ST_TAIL  = 3'b110
    } link_state_e;

endpackage : qflash_pkg

// ==== word_buf2.sv ====
`timescale 1ns/100ps
module word_buf2 #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    output logic [W-1:0]      out_data_o,
    output logic              out_valid_o,
    input  wire logic         out_ready_i
);

    // ****************************************************************
    // Two slots; slot 0 is the head and drives the output directly
    // ****************************************************************
    logic [W-1:0] slot_q [0:1];
    logic [1:0]   vld_q;
    logic         push;
    logic         pop;

    // Full only when the spare slot holds a word
    assign in_ready_o  = ~vld_q[1];
    assign push        = in_valid_i & ~vld_q[1];
    assign pop         = vld_q[0] & out_ready_i;
    assign out_data_o  = slot_q[0];
    assign out_valid_o = vld_q[0];

    // Slot occupancy
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            vld_q <= 2'h0;
        end else begin
            vld_q[0] <= vld_q[1] | push | (vld_q[0] & ~pop);
            vld_q[1] <= vld_q[1] ? ~pop : (push & vld_q[0] & ~pop);
        end
    end

    // Slot data; the spare moves up when the head is taken
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            slot_q[0] <= '0;
            slot_q[1] <= '0;
        end else begin
            if (push && (!vld_q[0] || (pop && !vld_q[1]))) begin
                slot_q[0] <= in_data_i;
            end else if (pop && vld_q[1]) begin
                slot_q[0] <= slot_q[1];
            end
            if (push && vld_q[0] && !pop) begin
                slot_q[1] <= in_data_i;
            end
        end
    end

endmodule : word_buf2

// ==== flash_model.sv ====
`timescale 1ns/100ps
// ****************************************************************
// Serial flash stand-in: takes the header, launches read nibbles
// ****************************************************************
module flash_model (
    input  wire logic        link_clk_i,
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic [3:0]  sd_i,
    output logic [3:0]       sd_o,
    output logic [31:0]      hdr_o,
    output int               falls_o,
    output int               lead_o,
    output int               tail_o,
    output logic             idle_bad_o
);
    logic rose_q;

    initial begin
        sd_o = 4'h5;
        hdr_o = '0;
        falls_o = 0;
        lead_o = 0;
        tail_o = 0;
        idle_bad_o = 1'b0;
        rose_q = 1'b0;
    end
    // New frame clears the fall and lead counters
    always @(negedge cs_n_i) begin
        falls_o = 0;
        lead_o = 0;
        rose_q = 1'b0;
    end
    // Lead and tail lengths, idle clock watch; released lines toggle
    always @(posedge link_clk_i) begin
        if (!cs_n_i && !rose_q) lead_o++;
        if (!cs_n_i) tail_o++;
        if (cs_n_i && sclk_i) idle_bad_o <= 1'b1;
        if (cs_n_i || falls_o < 32) sd_o <= ~sd_o;
    end
    // Header bits are taken on the rising edge, MSB first
    always @(posedge sclk_i) begin
        rose_q = 1'b1;
        if (falls_o < 32) hdr_o = {hdr_o[30:0], sd_i[0]};
    end
    // Each read nibble launched on a falling edge, held to the next
    always @(negedge sclk_i) if (!cs_n_i) begin
        falls_o++;
        tail_o = 0;
        if (falls_o >= 32) sd_o <= 4'((falls_o - 32) * 7 + 3);
    end
endmodule : flash_model

// ==== qflash_read_ctrl_tb.sv ====
`timescale 1ns/100ps
// ****************************************************************
// Frame-level bench with a flash model and a stalling reader
// ****************************************************************
module qflash_read_ctrl_tb;
    import qflash_pkg::*;
    logic ref_clk = 0, link_clk = 0, reset_n = 0, rd_ready = 0;
    logic [1:0] read_mode = 0, pin_mode = 0, cs_delay = 0;
    logic [LEN_W-1:0] word_len = 0;
    logic [CNT_W-1:0] word_cnt = 0;
    logic [DIV_W-1:0] clk_div = 0;
    logic evt_word = 0, evt_frame = 0, mm_req = 0, sw_req = 0;
    logic [ADDR_W-1:0] mm_addr = 0, sw_addr = 0;
    logic [CMD_W-1:0] sw_cmd = 0;
    logic busy, rd_last, rd_valid, event_p, sclk, cs_n, idle_bad;
    logic [WORD_W-1:0] rd_data;
    logic [3:0] sd_out, sd_oe_n, sd_mdl, sd_in;
    logic [31:0] hdr, rnd = 32'hdf9e45d2;
    int falls, lead, tail, n_ev, slow = 0, n_fail = 0, total_checks = 0;
    logic [128:0] expq[$];

    always #12.5 ref_clk = ~ref_clk;
    initial begin
        #7;
        forever #32 link_clk = ~link_clk;
    end
    // Pin level: the controller wins where it drives, else the flash
    assign sd_in = (sd_out & ~sd_oe_n) | (sd_mdl & sd_oe_n);

    qflash_read_ctrl qflash_read_ctrl_i (.ref_clk_i(ref_clk),
        .reset_n_i(reset_n), .link_clk_i(link_clk),
        .read_mode_i(read_mode), .pin_mode_i(pin_mode),
        .word_len_i(word_len), .word_cnt_i(word_cnt),
        .cs_delay_i(cs_delay), .clk_div_i(clk_div),
        .evt_word_i(evt_word), .evt_frame_i(evt_frame),
        .mm_req_i(mm_req), .mm_addr_i(mm_addr), .sw_req_i(sw_req),
        .sw_cmd_i(sw_cmd), .sw_addr_i(sw_addr), .busy_o(busy),
        .rd_data_o(rd_data), .rd_last_o(rd_last),
        .rd_valid_o(rd_valid), .rd_ready_i(rd_ready),
        .event_o(event_p), .sclk_o(sclk), .cs_n_o(cs_n),
        .sd_o(sd_out), .sd_oe_n_o(sd_oe_n), .sd_i(sd_in));
    flash_model flash_model_i (.link_clk_i(link_clk), .sclk_i(sclk),
        .cs_n_i(cs_n), .sd_i(sd_in), .sd_o(sd_mdl), .hdr_o(hdr),
        .falls_o(falls), .lead_o(lead), .tail_o(tail),
        .idle_bad_o(idle_bad));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    // Word as the flash pattern predicts it, right aligned
    function automatic logic [127:0] expw(input int k0, input int len,
                                          input int w, input bit p3);
        logic [127:0] r;
        logic [3:0]   nb;
        r = '0;
        for (int i = 0; i < (len + w - 1) / w; i++) begin
            nb = 4'((k0 + i) * 7 + 3);
            r = (r << w) | (w == 4 ? nb : w == 2 ? nb[1:0] :
                            p3 ? nb[0] : nb[1]);
        end
        if (len < 128) r &= (128'h1 << len) - 1;
        return r;
    endfunction : expw

    task automatic chk(input string what, input logic [128:0] e,
                       input logic [128:0] s);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask : chk

    task close_out;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out

    // Reader stalls at random; the oldest note is compared per handover
    always @(negedge ref_clk) begin
        rnd <= xs(rnd);
        rd_ready <= 32'(rnd[2:0]) >= slow;
    end
    always @(posedge ref_clk) begin
        if (event_p === 1'b1) n_ev++;
        if (reset_n && rd_valid === 1'b1 && rd_ready) begin
            if (expq.size() == 0)
                chk("spare word", 0, {rd_last, rd_data});
            else chk("word", expq.pop_front(), {rd_last, rd_data});
        end
    end

    // One frame; sw selects the software path and per-word events
    task automatic run(input logic [1:0] rm, input logic [1:0] pm,
                       input int len, input int cnt, input int dly,
                       input int dv, input bit sw);
        int w, nf, t, ex;
        logic [31:0] hx;
        w = rm == RD_QUAD ? 4 : rm == RD_DUAL ? 2 : 1;
        nf = (len + w - 1) / w;
        ex = (2 * dly + 2) * (dv + 1);
        @(negedge ref_clk);
        {read_mode, pin_mode, cs_delay} = {rm, pm, 2'(dly)};
        word_len = LEN_W'(len - 1);
        word_cnt = CNT_W'(cnt - 1);
        clk_div = DIV_W'(dv);
        {evt_word, evt_frame, slow} = {sw, 1'b1, sw ? 32'd6 : 32'd1};
        {mm_addr, sw_cmd, sw_addr} = {rnd[23:0], rnd[7:0], rnd[31:8]};
        hx = sw ? {sw_cmd, sw_addr} : {rm == RD_QUAD ? CMD_QUAD :
              rm == RD_DUAL ? CMD_DUAL : CMD_SINGLE, mm_addr};
        for (int j = 0; j < cnt; j++)
            expq.push_back({j == cnt - 1, expw(j * nf, len, w, pm == PINS_3)});
        n_ev = 0;
        {mm_req, sw_req} = {!sw, 1'b1};
        t = 0;
        while (busy !== 1'b1 && t < 50) begin
            @(negedge ref_clk);
            t++;
        end
        {mm_req, sw_req} = 2'b00;
        t = 0;
        while ((busy !== 1'b0 || cs_n !== 1'b1 || expq.size() > 0)
               && t < 20000) begin
            @(negedge ref_clk);
            t++;
        end
        if (t >= 20000) chk("frame end", 1, 0);
        chk("header", hx, hdr);
        chk("falls", 32 + cnt * nf, falls);
        chk("lead", 1, lead >= ex - 1 && lead <= ex + 1);
        chk("tail", 1, tail >= 4 * dv + 5);
        chk("events", sw ? cnt : 1, n_ev);
        chk("idle clock", 0, idle_bad);
        $display("test done mode %0d pins %0d len %0d words %0d",
                 rm, pm, len, cnt);
    endtask : run

    initial begin
        #2000000;
        n_fail++;
        $display("BAD watchdog expected end seen timeout");
        close_out();
    end

    // Reset, idle pins, then a table of frames
    initial begin
        repeat (8) @(negedge ref_clk);
        chk("reset pins", {3'b100, OE_OFF},
            {cs_n, sclk, busy, sd_oe_n});
        reset_n = 1;
        repeat (4) @(negedge ref_clk);
        run(RD_SINGLE, PINS_3, 8, 2, 0, 1, 0);
        run(RD_DUAL, PINS_4, 1, 3, 3, 1, 1);
        run(RD_QUAD, PINS_6, 128, 2, 1, 2, 0);
        run(RD_SINGLE, PINS_6, 13, 4, 2, 1, 1);
        run(RD_QUAD, PINS_6, 5, 3, 0, 3, 1);
        close_out();
    end
endmodule : qflash_read_ctrl_tb
